// File: rtl/dpll_cfg_pkg.sv
package dpll_cfg_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] TRIM_ADDR = 8'h00;
    localparam logic [7:0] HOLD_ADDR = 8'h04;
    localparam logic [7:0] BW_ADDR = 8'h08;
    localparam logic [7:0] DAMP_ADDR = 8'h0c;
    localparam logic [7:0] SLEW_ADDR = 8'h10;
    localparam logic [7:0] CTRL_ADDR = 8'h14;
    localparam logic [7:0] STAT_ADDR = 8'h18;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h1c;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h20;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [15:0] HOLD_RST = 16'h3800;
    localparam logic [15:0] BW_RST = 16'h7058;
    localparam logic [15:0] DAMP_RST = 16'h2901;
    localparam logic [31:0] SLEW_RST = 32'h01ffffff;
    localparam logic [1:0] CTRL_RST = 2'h1;

    // ------------------------------------------------------------
    // Writable bit masks
    // ------------------------------------------------------------
    localparam logic [15:0] DAMP_WMASK = 16'h3f3f;
    localparam logic [31:0] SLEW_WMASK = 32'h1fffffff;

    // ------------------------------------------------------------
    // Field positions and limits
    // ------------------------------------------------------------
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_UPD_DIS_BIT = 1;
    localparam logic [4:0] COARSE_MAX = 5'h14;
    localparam logic [3:0] HISTORY_MAX = 4'ha;
    localparam int IRQ_W = 2;
    localparam int IRQ_LIMIT_BIT = 0;
    localparam int IRQ_CFG_BIT = 1;

endpackage

// File: rtl/lock_loss_limit.sv
`timescale 1ns/10ps
`default_nettype none

module lock_loss_limit
    import dpll_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] lol_count,
    input wire logic [3:0] threshold,
    output logic limit_flag,
    output logic rise_pulse
);

    logic flag_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= (lol_count > threshold);
        end
    end

    assign limit_flag = flag_reg;
    assign rise_pulse = (lol_count > threshold) && !flag_reg;

endmodule

`default_nettype wire

// File: rtl/dpll_filter_holdover_config.sv
// Overview of operation
// - Trim is signed 8-bit, resets zero
// - Hold coarse bandwidth, reset 7, zero bypasses
// - Hold coarse bandwidth clamped to 20
// - Hold fine bandwidth zero bypasses filter
// - History code selects seconds, reset zero
// - Limit flag while count exceeds threshold
// - Acquire bandwidth fields, reset 0xE/0
// - Normal bandwidth fields, reset 0xB/0
// - Acquire damping fields, reset 5/1
// - Normal damping fields, reset 0/1
// - 29-bit slew limit, reset 0x1ffffff
// - Auto switch picks acquire while acquiring
`timescale 1ns/10ps
`default_nettype none

module dpll_filter_holdover_config
    import dpll_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acquiring,
    input wire logic [3:0] lol_count,
    output logic signed [7:0] trim_offset,
    output logic hold_filter_bypass,
    output logic [4:0] hold_filter_coarse_bw,
    output logic [2:0] hold_filter_fine_bw,
    output logic [3:0] hold_history,
    output logic [4:0] active_coarse_bandwidth,
    output logic [2:0] active_fine_bandwidth,
    output logic [2:0] active_coarse_damping,
    output logic [2:0] active_fine_damping,
    output logic [28:0] slew_limit,
    output logic filter_update_dis,
    output logic lock_loss_limit_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic [7:0] trim_reg;
    logic [15:0] hold_reg;
    logic [15:0] bw_reg;
    logic [15:0] damp_reg;
    logic [31:0] slew_reg;
    logic [1:0] ctrl_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [31:0] rdata_next;
    logic [31:0] prdata_reg;
    logic limit_flag;
    logic limit_rise;
    logic cfg_write;
    logic [IRQ_W-1:0] irq_event;
    logic [4:0] hold_coarse_raw;

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_comb
    begin
        addr_hit = 1'b1;
        case (paddr)
            TRIM_ADDR, HOLD_ADDR, BW_ADDR, DAMP_ADDR, SLEW_ADDR,
            CTRL_ADDR, STAT_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_hit;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // trim register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            trim_reg <= TRIM_RST;
        else if (wr_en && paddr == TRIM_ADDR)
            trim_reg <= pwdata[7:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hold_reg <= HOLD_RST;
        else if (wr_en && paddr == HOLD_ADDR)
            hold_reg <= pwdata[15:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            bw_reg <= BW_RST;
        else if (wr_en && paddr == BW_ADDR)
            bw_reg <= pwdata[15:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            damp_reg <= DAMP_RST;
        else if (wr_en && paddr == DAMP_ADDR)
            damp_reg <= pwdata[15:0] & DAMP_WMASK;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            slew_reg <= SLEW_RST;
        else if (wr_en && paddr == SLEW_ADDR)
            slew_reg <= pwdata & SLEW_WMASK;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_reg <= CTRL_RST;
        else if (wr_en && paddr == CTRL_ADDR)
            ctrl_reg <= pwdata[1:0];
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Config write while the filter still updates breaks the
    // reconfiguration sequence; flag it so software can see it.
    // unprotected reconfiguration flagged
    assign cfg_write = wr_en && !ctrl_reg[CTRL_UPD_DIS_BIT] &&
        (paddr == HOLD_ADDR || paddr == BW_ADDR ||
         paddr == DAMP_ADDR || paddr == SLEW_ADDR ||
         paddr == TRIM_ADDR);

    always_comb
    begin
        irq_event = '0;
        irq_event[IRQ_LIMIT_BIT] = limit_rise;
        irq_event[IRQ_CFG_BIT] = cfg_write;
    end

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++)
        begin : g_irq
            // Set wins over a same-cycle clear
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    irq_stat_reg[gi] <= 1'b0;
                else if (irq_event[gi])
                    irq_stat_reg[gi] <= 1'b1;
                else if (wr_en && paddr == IRQ_STAT_ADDR && pwdata[gi])
                    irq_stat_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask_reg <= '0;
        else if (wr_en && paddr == IRQ_MASK_ADDR)
            irq_mask_reg <= pwdata[IRQ_W-1:0];
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Sampled in setup so data is from a flop during access
    always_comb
    begin
        rdata_next = 32'h00000000;
        case (paddr)
            TRIM_ADDR: rdata_next = {24'h000000, trim_reg};
            HOLD_ADDR: rdata_next = {16'h0000, hold_reg};
            BW_ADDR: rdata_next = {16'h0000, bw_reg};
            DAMP_ADDR: rdata_next = {16'h0000, damp_reg};
            SLEW_ADDR: rdata_next = slew_reg;
            CTRL_ADDR: rdata_next = {30'h00000000, ctrl_reg};
            STAT_ADDR: rdata_next = {31'h00000000, limit_flag};
            IRQ_STAT_ADDR: rdata_next = {30'h00000000, irq_stat_reg};
            IRQ_MASK_ADDR: rdata_next = {30'h00000000, irq_mask_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prdata_reg <= 32'h00000000;
        else if (rd_en)
            prdata_reg <= rdata_next;
    end

    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // Field outputs to the loop
    // ------------------------------------------------------------
    // signed trim
    assign trim_offset = trim_reg;

    assign hold_coarse_raw = hold_reg[15:11];
    assign hold_filter_coarse_bw = (hold_coarse_raw > COARSE_MAX) ?
        COARSE_MAX : hold_coarse_raw;
    assign hold_filter_fine_bw = hold_reg[10:8];
    // zero coarse bypasses; zero fine bypasses
    assign hold_filter_bypass = (hold_coarse_raw == 5'h00) ||
        (hold_reg[10:8] == 3'h0);
    // history code; codes above ten undefined, saturated
    assign hold_history = (hold_reg[7:4] > HISTORY_MAX) ?
        HISTORY_MAX : hold_reg[7:4];

    // pick acquire set only when auto and acquiring
    always_comb
    begin
        if (ctrl_reg[CTRL_AUTO_BIT] && acquiring)
        begin
            active_coarse_bandwidth = bw_reg[15:11];
            active_fine_bandwidth = bw_reg[10:8];
            active_coarse_damping = damp_reg[13:11];
            active_fine_damping = damp_reg[10:8];
        end
        else
        begin
            active_coarse_bandwidth = bw_reg[7:3];
            active_fine_bandwidth = bw_reg[2:0];
            active_coarse_damping = damp_reg[5:3];
            active_fine_damping = damp_reg[2:0];
        end
    end

    // slew limit to core; software margin
    assign slew_limit = slew_reg[28:0];
    assign filter_update_dis = ctrl_reg[CTRL_UPD_DIS_BIT];

    // ------------------------------------------------------------
    // Lock loss limit
    // ------------------------------------------------------------
    // threshold compare
    lock_loss_limit u_lol
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .lol_count(lol_count),
        .threshold(hold_reg[3:0]),
        .limit_flag(limit_flag),
        .rise_pulse(limit_rise)
    );

    assign lock_loss_limit_flag = limit_flag;

endmodule

`default_nettype wire

// File: dv/dpll_cfg_chk.sv
`timescale 1ns/10ps
`default_nettype none

module dpll_cfg_chk
    import dpll_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic acquiring,
    input wire logic [3:0] lol_count,
    input wire logic signed [7:0] trim_offset,
    input wire logic hold_filter_bypass,
    input wire logic [4:0] hold_filter_coarse_bw,
    input wire logic [2:0] hold_filter_fine_bw,
    input wire logic [3:0] hold_history,
    input wire logic [4:0] active_coarse_bandwidth,
    input wire logic [28:0] slew_limit,
    input wire logic lock_loss_limit_flag
);
    // ------------------------------------------------------------
    // Register bank properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    sequence damp_read;
        psel && !penable && !pwrite && paddr == DAMP_ADDR;
    endsequence
    sequence access_phase;
        psel && penable;
    endsequence
    a_coarse_clamp: assert property (hold_filter_coarse_bw <= 5'h14)
        else $error("holdover coarse bandwidth above clamp");
    a_fine_bypass: assert property (
        hold_filter_fine_bw == 3'h0 |-> hold_filter_bypass)
        else $error("zero fine bandwidth without bypass");
    a_history_limit: assert property (hold_history <= 4'ha)
        else $error("holdover history above ten");
    a_limit_idle: assert property (
        $past(lol_count) == 4'h0 |-> !lock_loss_limit_flag)
        else $error("limit flag set with zero count");
    a_trim_by_write: assert property (
        !$stable(trim_offset) |-> $past(wr_acc && paddr == TRIM_ADDR))
        else $error("trim changed without write");
    a_slew_by_write: assert property (
        !$stable(slew_limit) |-> $past(wr_acc && paddr == SLEW_ADDR))
        else $error("slew limit changed without write");
    a_damp_reserved: assert property (
        damp_read ##1 access_phase |->
        prdata[15:14] == 2'h0 && prdata[7:6] == 2'h0)
        else $error("damping reserved bits read nonzero");
    a_select_cause: assert property (
        $changed(active_coarse_bandwidth) |->
        $changed(acquiring) || $past(wr_acc))
        else $error("active bandwidth changed without cause");
endmodule

bind dpll_filter_holdover_config dpll_cfg_chk u_chk (.clk_sys, .rst_n, .psel,
    .penable, .pwrite, .paddr, .prdata, .acquiring, .lol_count, .trim_offset,
    .hold_filter_bypass, .hold_filter_coarse_bw, .hold_filter_fine_bw,
    .hold_history, .active_coarse_bandwidth, .slew_limit, .lock_loss_limit_flag);

`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import dpll_cfg_pkg::*;
;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, acquiring;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] lol_count, hold_history;
    logic signed [7:0] trim_offset;
    logic hold_filter_bypass, filter_update_dis, lock_loss_limit_flag, irq;
    logic err;
    logic [4:0] hold_filter_coarse_bw, active_coarse_bandwidth;
    logic [2:0] hold_filter_fine_bw, active_fine_bandwidth;
    logic [2:0] active_coarse_damping, active_fine_damping;
    logic [28:0] slew_limit;
    int n_fail, cmp_count;

    dpll_filter_holdover_config DUT (.clk_sys, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .acquiring,
        .lol_count, .trim_offset, .hold_filter_bypass, .hold_filter_coarse_bw,
        .hold_filter_fine_bw, .hold_history, .active_coarse_bandwidth,
        .active_fine_bandwidth, .active_coarse_damping, .active_fine_damping,
        .slew_limit, .filter_update_dis, .lock_loss_limit_flag, .irq);

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Waits on pready; never assumes the zero-wait answer
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(negedge clk_sys);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, rdv, e);
        @(negedge clk_sys);
    endtask

    task automatic sel(input logic au, ac, input logic [13:0] e);
        @(posedge clk_sys);
        acquiring <= ac;
        wr(CTRL_ADDR, {30'h0, 1'b1, au});
        check("active", {18'h0, active_coarse_bandwidth, active_fine_bandwidth,
            active_coarse_damping, active_fine_damping}, {18'h0, e});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, acquiring} = '0;
        {lol_count, n_fail, cmp_count} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check("rst hold", {24'h0, hold_filter_coarse_bw, hold_filter_bypass,
            hold_filter_fine_bw[1:0]}, 32'h3c);
        rd("trim", TRIM_ADDR, 32'h0);
        rd("hold", HOLD_ADDR, 32'h3800);
        rd("bw", BW_ADDR, 32'h7058);
        rd("damp", DAMP_ADDR, 32'h2901);
        rd("slew", SLEW_ADDR, 32'h01ffffff);
        rd("ctrl", CTRL_ADDR, 32'h1);
        check("no slverr", {31'h0, err}, 32'h0);
        check("pready", {31'h0, pready}, 32'h1);
        wr(CTRL_ADDR, 32'h3);
        wr(HOLD_ADDR, 32'ha913);
        check("hold out", {19'h0, hold_filter_coarse_bw, hold_filter_fine_bw,
            hold_filter_bypass, hold_history},
            {19'h0, 5'd20, 3'd1, 1'b0, 4'd1});
        wr(HOLD_ADDR, 32'h00f3);
        check("bypass", {27'h0, hold_filter_bypass, hold_history},
            32'h1a);
        wr(TRIM_ADDR, 32'h80);
        check("trim out", {24'h0, trim_offset}, 32'h80);
        wr(SLEW_ADDR, 32'hffffffff);
        rd("slew", SLEW_ADDR, 32'h1fffffff);
        check("slew out", {3'h0, slew_limit}, 32'h1fffffff);
        wr(SLEW_ADDR, 32'h00e66666);
        rd("slew margin", SLEW_ADDR, 32'h00e66666);
        check("slew margin out", {3'h0, slew_limit}, 32'h00e66666);
        wr(DAMP_ADDR, 32'hffffea11);
        rd("damp", DAMP_ADDR, 32'h2a11);
        wr(BW_ADDR, 32'ha35e);
        sel(1'b1, 1'b1, {5'd20, 3'd3, 3'd5, 3'd2});
        sel(1'b0, 1'b1, {5'd11, 3'd6, 3'd2, 3'd1});
        sel(1'b1, 1'b0, {5'd11, 3'd6, 3'd2, 3'd1});
        @(posedge clk_sys);
        lol_count <= 4'd3;
        repeat (3) @(posedge clk_sys);
        lol_count <= 4'd4;
        @(negedge clk_sys);
        check("at limit", {31'h0, lock_loss_limit_flag}, 32'h0);
        repeat (2) @(posedge clk_sys);
        rd("status", STAT_ADDR, 32'h1);
        wr(IRQ_MASK_ADDR, 32'h1);
        check("irq on", {31'h0, irq}, 32'h1);
        @(posedge clk_sys);
        lol_count <= 4'd0;
        wr(IRQ_STAT_ADDR, 32'h1);
        rd("irq stat", IRQ_STAT_ADDR, 32'h0);
        check("irq off", {31'h0, irq}, 32'h0);
        wr(CTRL_ADDR, 32'h1);
        check("upd dis", {31'h0, filter_update_dis}, 32'h0);
        wr(TRIM_ADDR, 32'h0);
        rd("cfg event", IRQ_STAT_ADDR, 32'h2);
        rd("unmapped", 8'h24, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        stop_test;
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        #400000;
        n_fail++;
        stop_test;
    end
endmodule

`default_nettype wire
